/* inc/nand_host_consts.vh */
/*
  Constants for the NAND bus-cycle host controller: cycle kinds,
  address packing positions, pointer command codes and strobe timing.
  Assumes inclusion by bare name from design files.
*/
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH

// ----------------------------------------
// Cycle kinds on the user port
// ----------------------------------------
`define OP_CMD 3'h0
`define OP_ADDR 3'h1
`define OP_WDATA 3'h2
`define OP_RDATA 3'h3
`define OP_IDLE 3'h4

// ----------------------------------------
// Command codes and address packing
// ----------------------------------------
`define CMD_PTR_A 8'h00
`define CMD_PTR_B 8'h01
`define ADDR_CYCLES 2'h3
`define ADDR_HI_BIT 24
`define ADDR_A8 8

// ----------------------------------------
// Strobe timing, ns, and clock period, ns
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define T_SETUP_NS 25
`define T_PULSE_NS 35
`define T_HOLD_NS 25

`endif

/* core/nand_addr_pack.v */
/*
  Splits a 25-bit flash address into three address bytes for the
  selected cycle index. Assumes mode and index are held stable.
*/
`include "nand_host_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module nand_addr_pack (
  // Address and selection
  input wire [24:0] addr,
  input wire wide,
  input wire [1:0] index,
  // Byte out
  output reg [7:0] addr_byte
);

  // Word mode: A1 is the LSB, so shift down one place
  wire [24:0] eff = wide ? {1'b0, addr[24:1]} : addr;

  always @* begin
    case (index)
      2'h0: addr_byte = eff[7:0];
      2'h1: addr_byte = eff[16:9];
      2'h2: addr_byte = eff[24:17];
      default: addr_byte = 8'h00;
    endcase
  end

endmodule // nand_addr_pack

`default_nettype wire

/* core/nand_host_ctrl.v */
/*
  Host controller that drives a small-page NAND flash through its pins:
  chip select, latch strobes, input and output strobes, bidirectional
  I/O bus, program lock, spare select, and the shared busy line.
  Assumes a single clock; busy and bus inputs are asynchronous pins.
*/
`include "nand_host_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module nand_host_ctrl #(
  parameter WIDE = 0,
  parameter integer SETUP_CYC = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter integer PULSE_CYC = (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter integer HOLD_CYC = (`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire CORE_CLK,
  input wire RST,
  input wire CE,
  // User request
  input wire REQ_VALID,
  input wire [2:0] REQ_OP,
  input wire [7:0] REQ_CMD,
  input wire [24:0] REQ_ADDR,
  input wire [15:0] REQ_WDATA,
  input wire REQ_PROTECT,
  input wire REQ_SPARE_SKIP,
  output wire REQ_READY,
  // User answer
  output reg RSP_VALID,
  output reg [15:0] RSP_RDATA,
  output reg RSP_REFUSED,
  output wire DEV_BUSY,
  // Flash pins
  output reg CHIP_SELECT_N,
  output reg CMD_LATCH_STROBE,
  output reg ADDR_LATCH_STROBE,
  output reg INPUT_STROBE_N,
  output reg OUTPUT_STROBE_N,
  output reg PROGRAM_LOCK_N,
  output reg SPARE_AREA_SELECT,
  input wire [15:0] IO_IN,
  output reg [15:0] IO_OUT,
  output reg IO_OE_N,
  input wire BUSY_FLAG_N
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_PULSE = 5'h04;
  localparam [4:0] S_HOLD = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg [4:0] state;
  reg [3:0] count;
  reg [2:0] op;
  reg [7:0] cmd;
  reg [24:0] addr;
  reg [1:0] addr_index;
  reg busy_meta;
  reg busy_sync;
  wire [7:0] addr_byte;

  function is_write;
    input [2:0] k;
    is_write = (k == `OP_CMD) || (k == `OP_ADDR) || (k == `OP_WDATA);
  endfunction

  // ----------------------------------------
  // Busy line synchroniser
  // ----------------------------------------
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end else if (CE) begin
      busy_meta <= BUSY_FLAG_N;
      busy_sync <= busy_meta;
    end
  end

  // Shared pull-up: any low means some memory busy
  assign DEV_BUSY = ~busy_sync;

  // Extra address cycles and word-mode 01h pointer are refused
  wire bad_req = (REQ_OP == `OP_ADDR && addr_index == `ADDR_CYCLES) ||
                 (WIDE != 0 && REQ_OP == `OP_CMD && REQ_CMD == `CMD_PTR_B) ||
                 (REQ_OP > `OP_IDLE);
  assign REQ_READY = (state == S_IDLE);

  nand_addr_pack u_pack (
    .addr(addr),
    .wide(WIDE != 0),
    .index(addr_index),
    .addr_byte(addr_byte)
  );

  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= S_IDLE;
      count <= 4'h0;
      op <= `OP_IDLE;
      cmd <= 8'h00;
      addr <= 25'h0000000;
      addr_index <= 2'h0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 16'h0000;
      RSP_REFUSED <= 1'b0;
      CHIP_SELECT_N <= 1'b1;
      CMD_LATCH_STROBE <= 1'b0;
      ADDR_LATCH_STROBE <= 1'b0;
      INPUT_STROBE_N <= 1'b1;
      OUTPUT_STROBE_N <= 1'b1;
      PROGRAM_LOCK_N <= 1'b0;
      SPARE_AREA_SELECT <= 1'b0;
      IO_OUT <= 16'h0000;
      IO_OE_N <= 1'b1;
    end else if (CE) begin
      RSP_VALID <= 1'b0;
      RSP_REFUSED <= 1'b0;
      // Level pins follow user settings; lock low protects from reset on
      PROGRAM_LOCK_N <= ~REQ_PROTECT;
      SPARE_AREA_SELECT <= REQ_SPARE_SKIP;
      case (state)
        S_IDLE: begin
          if (REQ_VALID && bad_req) begin
            RSP_REFUSED <= 1'b1;
            RSP_VALID <= 1'b1;
          end else if (REQ_VALID && REQ_OP == `OP_IDLE) begin
            // Deselect: device stays active itself if still busy
            CHIP_SELECT_N <= 1'b1;
            IO_OE_N <= 1'b1;
            RSP_VALID <= 1'b1;
          end else if (REQ_VALID) begin
            op <= REQ_OP;
            cmd <= REQ_CMD;
            if (REQ_OP == `OP_ADDR && addr_index == 2'h0)
              addr <= REQ_ADDR;
            CHIP_SELECT_N <= 1'b0;
            CMD_LATCH_STROBE <= (REQ_OP == `OP_CMD);
            ADDR_LATCH_STROBE <= (REQ_OP == `OP_ADDR);
            count <= SETUP_CYC[3:0];
            state <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            count <= PULSE_CYC[3:0];
            state <= S_PULSE;
            if (is_write(op)) begin
              INPUT_STROBE_N <= 1'b0;
              IO_OE_N <= 1'b0;
              if (op == `OP_CMD)
                IO_OUT <= {8'h00, cmd};
              else if (op == `OP_ADDR)
                IO_OUT <= {8'h00, addr_byte};
              else
                IO_OUT <= (WIDE != 0) ? REQ_WDATA : {8'h00, REQ_WDATA[7:0]};
            end else begin
              OUTPUT_STROBE_N <= 1'b0;
              IO_OE_N <= 1'b1;
            end
          end
        end
        S_PULSE: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            if (op == `OP_RDATA)
              // Bus input is sampled late in the pulse, settled by then
              RSP_RDATA <= (WIDE != 0) ? IO_IN : {8'h00, IO_IN[7:0]};
            INPUT_STROBE_N <= 1'b1;
            OUTPUT_STROBE_N <= 1'b1;
            count <= HOLD_CYC[3:0];
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (count > 4'h1) begin
            count <= count - 4'h1;
          end else begin
            CMD_LATCH_STROBE <= 1'b0;
            ADDR_LATCH_STROBE <= 1'b0;
            IO_OE_N <= 1'b1;
            if (op == `OP_CMD)
              addr_index <= 2'h0;
            else if (op == `OP_ADDR)
              addr_index <= addr_index + 2'h1;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          RSP_VALID <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // nand_host_ctrl

`default_nettype wire

/* test/nand_host_checker.sv */
/* Pin-level checker for nand_host_ctrl.
   Assumes a bind onto its ports, one clock. */
`timescale 1ns/10ps
`default_nettype none
module nand_host_checker (
  // Clock, reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // User side
  input wire logic CE,
  input wire logic REQ_PROTECT,
  input wire logic DEV_BUSY,
  // Pins
  input wire logic CHIP_SELECT_N,
  input wire logic CMD_LATCH_STROBE,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic INPUT_STROBE_N,
  input wire logic OUTPUT_STROBE_N,
  input wire logic PROGRAM_LOCK_N,
  input wire logic [15:0] IO_OUT,
  input wire logic IO_OE_N,
  input wire logic BUSY_FLAG_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Busy line passes a two-flop sync
  sequence lo3; !BUSY_FLAG_N [*3]; endsequence
  sequence hi3; BUSY_FLAG_N [*3]; endsequence
  AST_CMD: assert property ($rose(INPUT_STROBE_N) && CMD_LATCH_STROBE
    |-> !CHIP_SELECT_N && !ADDR_LATCH_STROBE && OUTPUT_STROBE_N) else $error("cmd cycle");
  AST_ADDR: assert property ($rose(INPUT_STROBE_N) && ADDR_LATCH_STROBE
    |-> !CHIP_SELECT_N && !CMD_LATCH_STROBE && OUTPUT_STROBE_N) else $error("addr cycle");
  AST_DATA: assert property ($rose(INPUT_STROBE_N) && !CMD_LATCH_STROBE
    && !ADDR_LATCH_STROBE |-> !CHIP_SELECT_N && OUTPUT_STROBE_N) else $error("data cycle");
  AST_READ: assert property ($fell(OUTPUT_STROBE_N) |-> !CHIP_SELECT_N
    && INPUT_STROBE_N && IO_OE_N && !CMD_LATCH_STROBE && !ADDR_LATCH_STROBE)
    else $error("read cycle");
  AST_UPPER: assert property (!IO_OE_N && (CMD_LATCH_STROBE || ADDR_LATCH_STROBE)
    |-> IO_OUT[15:8] == 8'h00) else $error("upper lines");
  AST_LOCK: assert property (CE |=> PROGRAM_LOCK_N == !$past(REQ_PROTECT))
    else $error("lock pin");
  AST_BUSY: assert property (lo3 |-> DEV_BUSY) else $error("busy seen");
  AST_READY: assert property (hi3 |-> !DEV_BUSY) else $error("ready seen");
endmodule // nand_host_checker
`default_nettype wire

/* test/nand_dev_model.sv */
/* Behavioural NAND device on the far side of the pins.
   Assumes host pins from the controller, no clock. */
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model (
  // Host pins
  input wire logic cs_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic ostb_n,
  input wire logic wp_n,
  input wire logic [15:0] io_out,
  input wire logic oe_n,
  // Device side
  output logic [15:0] io_in,
  output logic busy_n
);
  logic [7:0] cmd;
  logic [7:0] ab [0:2];
  logic [15:0] wdat;
  logic [15:0] rdat = 16'h0000;
  logic busy_q = 1'b1;
  int na = 0;
  int col = 0;
  // Undriven bus shows the complement of the last read value, never the value itself
  assign io_in = !oe_n ? io_out : (!cs_n && !ostb_n) ? rdat : ~rdat;
  assign busy_n = busy_q;
  always @(posedge we_n) begin
    if (!cs_n && ostb_n && cle && !ale) begin
      cmd = io_out[7:0];
      na = 0;
      col = 0;
      if ((cmd == 8'h10 || cmd == 8'hd0) && wp_n) begin
        busy_q <= 1'b0;
        busy_q <= #2000 1'b1;
      end
    end
    if (!cs_n && ostb_n && ale && !cle) begin
      if (na < 3) ab[na] = io_out[7:0];
      na = na + 1;
    end
    if (!cs_n && ostb_n && !ale && !cle) wdat = io_out;
  end
  always @(negedge ostb_n) begin
    if (!cs_n && we_n && !ale && !cle) begin
      rdat = {8'ha5, ab[0] ^ col[7:0]};
      col = col + 1;
    end
  end
endmodule // nand_dev_model
`default_nettype wire

/* test/nand_host_ctrl_tb_top.sv */
/* Self-checking bench for nand_host_ctrl.
   Assumes byte mode and default strobe timing. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module nand_host_ctrl_tb_top;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic REQ_VALID = 1'b0;
  logic [2:0] REQ_OP = 3'h4;
  logic [7:0] REQ_CMD = 8'h00;
  logic [24:0] REQ_ADDR = 25'h1abcdef;
  logic [15:0] REQ_WDATA = 16'h1234;
  logic REQ_PROTECT = 1'b0;
  logic REQ_SPARE_SKIP = 1'b0;
  wire REQ_READY, RSP_VALID, RSP_REFUSED, DEV_BUSY, CHIP_SELECT_N, CMD_LATCH_STROBE;
  wire ADDR_LATCH_STROBE, INPUT_STROBE_N, OUTPUT_STROBE_N, PROGRAM_LOCK_N;
  wire SPARE_AREA_SELECT, IO_OE_N, BUSY_FLAG_N;
  wire [15:0] RSP_RDATA, IO_IN, IO_OUT;
  int err_count = 0;
  int check_count = 0;
  logic [15:0] rd;
  logic rf;
  always #20 CORE_CLK = ~CORE_CLK;
  nand_host_ctrl nand_host_ctrl_inst (.*);
  nand_dev_model nand_dev_model_inst (.cs_n(CHIP_SELECT_N), .cle(CMD_LATCH_STROBE),
    .ale(ADDR_LATCH_STROBE), .we_n(INPUT_STROBE_N), .ostb_n(OUTPUT_STROBE_N),
    .wp_n(PROGRAM_LOCK_N), .io_out(IO_OUT), .oe_n(IO_OE_N), .io_in(IO_IN),
    .busy_n(BUSY_FLAG_N));
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One request, held until taken, then wait for its answer
  task automatic op(input logic [2:0] o, input logic [7:0] c);
    int n;
    n = 0;
    REQ_OP <= o;
    REQ_CMD <= c;
    REQ_VALID <= 1'b1;
    // Sample on the falling edge, where outputs have settled
    do @(negedge CORE_CLK); while (REQ_READY !== 1'b1 && ++n < 99);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b0;
    do @(negedge CORE_CLK); while (RSP_VALID !== 1'b1 && ++n < 99);
    rd = RSP_RDATA;
    rf = RSP_REFUSED;
    @(posedge CORE_CLK);
    if (n >= 99) begin
      err_count++;
      report_and_stop;
    end
  endtask
  task automatic t_addr;
    op(3'h0, 8'h00);
    op(3'h1, 8'h00);
    op(3'h0, 8'h01);
    `CHK(nand_dev_model_inst.cmd, 8'h01)
    repeat (3) op(3'h1, 8'h00);
    `CHK(nand_dev_model_inst.ab[0], REQ_ADDR[7:0])
    `CHK(nand_dev_model_inst.ab[1], REQ_ADDR[16:9])
    `CHK(nand_dev_model_inst.ab[2], REQ_ADDR[24:17])
    op(3'h1, 8'h00);
    `CHK(rf, 1'b1)
  endtask
  task automatic t_data;
    op(3'h2, 8'h00);
    `CHK(nand_dev_model_inst.wdat[7:0], REQ_WDATA[7:0])
    op(3'h0, 8'h00);
    op(3'h3, 8'h00);
    `CHK(rd, {8'h00, REQ_ADDR[7:0]})
    op(3'h3, 8'h00);
    `CHK(rd, {8'h00, REQ_ADDR[7:0] ^ 8'h01})
  endtask
  task automatic t_lock;
    int n;
    n = 0;
    REQ_PROTECT <= 1'b1;
    op(3'h0, 8'h10);
    repeat (5) @(posedge CORE_CLK);
    `CHK(DEV_BUSY, 1'b0)
    REQ_PROTECT <= 1'b0;
    op(3'h0, 8'h10);
    repeat (5) @(posedge CORE_CLK);
    `CHK(DEV_BUSY, 1'b1)
    while (DEV_BUSY !== 1'b0 && ++n < 99) @(posedge CORE_CLK);
    `CHK(DEV_BUSY, 1'b0)
  endtask
  task automatic t_sel;
    REQ_SPARE_SKIP <= 1'b1;
    op(3'h4, 8'h00);
    `CHK(CHIP_SELECT_N, 1'b1)
    `CHK(SPARE_AREA_SELECT, 1'b1)
    op(3'h5, 8'h00);
    `CHK(rf, 1'b1)
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_addr;
    t_data;
    t_lock;
    t_sel;
    report_and_stop;
  end
endmodule // nand_host_ctrl_tb_top
bind nand_host_ctrl nand_host_checker nand_host_checker_inst (.*);
`default_nettype wire
